// ===== core/lvdsc_pkg.sv
/*
 * Offsets, fields, reset values and widths of the config block.
 * Assumes an 8-bit register port, 12-bit addresses.
 */
package lvdsc_pkg;

    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 8;
    localparam int SAMPLE_W  = 12;
    localparam int NUM_BUS   = 4;
    localparam int LANES_W   = SAMPLE_W * NUM_BUS;
    localparam int LFSR_W    = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [11:0] OFS_PAT_INVERT   = 12'h190;
    localparam logic [11:0] OFS_ENABLE       = 12'h200;
    localparam logic [11:0] OFS_MODE         = 12'h201;
    localparam logic [11:0] OFS_FRAME_LEN    = 12'h202;
    localparam logic [11:0] OFS_SOFT_ALIGN   = 12'h203;
    localparam logic [11:0] OFS_CONTROL      = 12'h204;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_PAT_INVERT    = 8'h00;
    localparam logic [7:0] RST_ENABLE        = 8'h01;
    localparam logic [7:0] RST_MODE          = 8'h01;
    localparam logic [7:0] RST_FRAME_LEN     = 8'h80;
    localparam logic [7:0] RST_SOFT_ALIGN    = 8'h01;
    localparam logic [7:0] RST_CONTROL       = 8'h02;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_PAT_INV_A    = 0;
    localparam int BIT_ENABLE       = 0;
    localparam int BIT_DEMUX        = 0;
    localparam int BIT_BUS_ALIGN    = 1;
    localparam int BIT_INTERLEAVE   = 2;
    localparam int POS_WIDTH_LO     = 4;
    localparam int POS_WIDTH_HI     = 5;
    localparam int BIT_SOFT_ALIGN_N = 0;
    localparam int BIT_FORMAT       = 1;
    localparam int POS_SRC_LO       = 2;
    localparam int POS_SRC_HI       = 3;
    localparam int BIT_SCRAMBLE     = 4;
    localparam int BIT_INVERTED     = 8;

    // Writable bits of each register; everything else reads as zero
    localparam logic [7:0] MASK_PAT_INVERT   = 8'h01;
    localparam logic [7:0] MASK_ENABLE       = 8'h01;
    localparam logic [7:0] MASK_MODE         = 8'h37;
    localparam logic [7:0] MASK_SOFT_ALIGN   = 8'h01;
    localparam logic [7:0] MASK_CONTROL      = 8'h1E;

    localparam logic [14:0] LFSR_SEED        = 15'h7FFF;

    typedef enum logic [1:0] {
        LVDSC_W12,
        LVDSC_W11,
        LVDSC_W10,
        LVDSC_W8
    } lvdsc_width_t;

    typedef enum logic [1:0] {
        LVDSC_SRC_PIN,
        LVDSC_SRC_TIMESTAMP,
        LVDSC_SRC_NONE,
        LVDSC_SRC_RSVD
    } lvdsc_src_t;

endpackage

// ===== core/lvdsc_lane_if.sv
/*
 * Four 12-bit lanes and four strobes.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface lvdsc_lane_if;
    logic [lvdsc_pkg::LANES_W-1:0] data;
    logic [lvdsc_pkg::NUM_BUS-1:0] strobe;

    modport src (output data, output strobe);
    modport dst (input  data, input  strobe);
endinterface

// ===== core/lvdsc_sync2.sv
/*
 * Two-flop synchroniser into core_clk.
 * Assumes independent bits; no bus coherence.
 */
`timescale 1ns/1ps
module lvdsc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] metaStage;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            metaStage <= '0;
            syncOut   <= '0;
        end else begin
            metaStage <= asyncIn;
            syncOut   <= metaStage;
        end
    end
endmodule

// ===== core/lvdsc_scrambler.sv
/*
 * Additive scrambler over all lanes and strobes.
 * Assumes clear is held while disabled, so it restarts from the seed.
 */
`timescale 1ns/1ps
module lvdsc_scrambler (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic scrambleOn,
    lvdsc_lane_if.dst laneIn,
    lvdsc_lane_if.src laneOut
);
    logic [lvdsc_pkg::LFSR_W-1:0] lfsr;
    logic [lvdsc_pkg::LFSR_W-1:0] next_lfsr;
    logic                         feedback;

    always_comb begin
        feedback  = lfsr[14] ^ lfsr[13];
        next_lfsr = {lfsr[13:0], feedback};
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= lvdsc_pkg::LFSR_SEED;
        end else if (clear) begin
            lfsr <= lvdsc_pkg::LFSR_SEED;
        end else if (scrambleOn) begin
            lfsr <= next_lfsr;
        end
    end

    // Each bus sees a 12-bit LFSR window offset by one more bit so lanes stay decorrelated
    always_comb begin
        laneOut.data   = laneIn.data;
        laneOut.strobe = laneIn.strobe;
        if (scrambleOn) begin
            for (int b = 0; b < lvdsc_pkg::NUM_BUS; b++) begin
                laneOut.data[b*12 +: 12] = laneIn.data[b*12 +: 12] ^ lfsr[b +: 12];
                laneOut.strobe[b]        = laneIn.strobe[b] ^ lfsr[14-b];
            end
        end
    end
endmodule

// ===== core/lvdsc_output_config.sv
/*
 * Config registers and output formatting of the sample interface:
 * enable, mode, frame length, soft alignment,
 * scrambling, source and format.
 * Assumes a register port on core_clk; link clock, SYSREF and
 * pins arrive asynchronously.
 */
`timescale 1ns/1ps

// Rules for this block and its software
// R1: Invert pattern bit 8 on bus A
// R2: Enable bit; off holds interface in reset
// R3: Frame counter held reset while disabled
// R4: Software disables before changing configuration
// R5: Calibration enable ordered around subsystem enable
// R6: Width field selects 12/11/10/8 bits
// R7: Interleave bit selects dual or single
// R8: Bus alignment bit staggers or aligns buses
// R9: Demux bit selects two or four buses
// R10: Frame length sets UIs per frame
// R11: One UI is one or two clocks
// R12: Software avoids frame length of four
// R13: Writing zero requests alignment like pin
// R14: Software request works for every source
// R15: Scramble bit scrambles lanes and strobes
// R16: Source field picks pin, timestamp, none
// R17: Format bit picks offset or two's complement
// R18: Aligning sends frame strobe on LSB
// R19: Software writes zero to reserved bits
module lvdsc_output_config (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    input  wire logic        linkClkIn,
    input  wire logic        sysrefIn,
    input  wire logic        alignPinSingleEnded_n,
    input  wire logic        timestampDiffInput_n,
    input  wire logic        timestampReceiverOn,
    input  wire logic [47:0] sampleIn,
    input  wire logic [11:0] userPattern,
    input  wire logic        activePatternUser,
    output logic      [47:0] busData,
    output logic      [3:0]  busStrobe,
    output logic      [3:0]  busEnable,
    output logic             outputsPowered,
    output logic             singleChannelMode,
    output logic             alignActive
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] patInvertReg;
    logic [7:0] enableReg;
    logic [7:0] modeReg;
    logic [7:0] frameLenReg;
    logic [7:0] softAlignReg;
    logic [7:0] controlReg;

    // Reserved bits are dropped on write so they always read as zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            patInvertReg <= lvdsc_pkg::RST_PAT_INVERT;
            enableReg    <= lvdsc_pkg::RST_ENABLE;
            modeReg      <= lvdsc_pkg::RST_MODE;
            frameLenReg  <= lvdsc_pkg::RST_FRAME_LEN;
            softAlignReg <= lvdsc_pkg::RST_SOFT_ALIGN;
            controlReg   <= lvdsc_pkg::RST_CONTROL;
        end else if (regWrite) begin
            case (regAddr)
                lvdsc_pkg::OFS_PAT_INVERT: begin
                    patInvertReg <= regWrData & lvdsc_pkg::MASK_PAT_INVERT;
                end
                lvdsc_pkg::OFS_ENABLE: begin
                    enableReg <= regWrData & lvdsc_pkg::MASK_ENABLE;
                end
                lvdsc_pkg::OFS_MODE: begin
                    modeReg <= regWrData & lvdsc_pkg::MASK_MODE;
                end
                lvdsc_pkg::OFS_FRAME_LEN: begin
                    frameLenReg <= regWrData;
                end
                lvdsc_pkg::OFS_SOFT_ALIGN: begin
                    softAlignReg <= regWrData & lvdsc_pkg::MASK_SOFT_ALIGN;
                end
                lvdsc_pkg::OFS_CONTROL: begin
                    controlReg <= regWrData & lvdsc_pkg::MASK_CONTROL;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                lvdsc_pkg::OFS_PAT_INVERT: regRdData <= patInvertReg;
                lvdsc_pkg::OFS_ENABLE:     regRdData <= enableReg;
                lvdsc_pkg::OFS_MODE:       regRdData <= modeReg;
                lvdsc_pkg::OFS_FRAME_LEN:  regRdData <= frameLenReg;
                lvdsc_pkg::OFS_SOFT_ALIGN: regRdData <= softAlignReg;
                lvdsc_pkg::OFS_CONTROL:    regRdData <= controlReg;
                default:                   regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    logic                    enabled;
    logic                    demuxBy2;
    logic                    busesAligned;
    logic                    interleave;
    lvdsc_pkg::lvdsc_width_t widthSel;
    lvdsc_pkg::lvdsc_src_t   alignSrc;
    logic                    scrambleOn;
    logic                    twosComplement;
    logic                    invertBusA;
    logic                    softAlignReq_n;

    always_comb begin
        enabled        = enableReg[lvdsc_pkg::BIT_ENABLE];
        demuxBy2       = modeReg[lvdsc_pkg::BIT_DEMUX];
        busesAligned   = modeReg[lvdsc_pkg::BIT_BUS_ALIGN];
        interleave     = modeReg[lvdsc_pkg::BIT_INTERLEAVE];
        widthSel       = lvdsc_pkg::lvdsc_width_t'(modeReg[lvdsc_pkg::POS_WIDTH_HI:lvdsc_pkg::POS_WIDTH_LO]);
        alignSrc       = lvdsc_pkg::lvdsc_src_t'(controlReg[lvdsc_pkg::POS_SRC_HI:lvdsc_pkg::POS_SRC_LO]);
        scrambleOn     = controlReg[lvdsc_pkg::BIT_SCRAMBLE];
        twosComplement = controlReg[lvdsc_pkg::BIT_FORMAT];
        invertBusA     = patInvertReg[lvdsc_pkg::BIT_PAT_INV_A];
        softAlignReq_n = softAlignReg[lvdsc_pkg::BIT_SOFT_ALIGN_N];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [3:0] pinsSync;
    logic       linkClkSync;
    logic       sysrefSync;
    logic       alignPinSync_n;
    logic       timestampSync_n;

    lvdsc_sync2 #(
        .WIDTH (4)
    ) u_pinSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  ({timestampDiffInput_n, alignPinSingleEnded_n, sysrefIn, linkClkIn}),
        .syncOut  (pinsSync)
    );

    always_comb begin
        linkClkSync     = pinsSync[0];
        sysrefSync      = pinsSync[1];
        alignPinSync_n  = pinsSync[2];
        timestampSync_n = pinsSync[3];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alignment request

    logic pinLevel_n;

    // R16: source selection
    always_comb begin
        case (alignSrc)
            lvdsc_pkg::LVDSC_SRC_PIN:       pinLevel_n = alignPinSync_n;
            lvdsc_pkg::LVDSC_SRC_TIMESTAMP: pinLevel_n = timestampReceiverOn ? timestampSync_n : 1'b1;
            default:                        pinLevel_n = 1'b1;
        endcase
    end

    // R13: software request acts like the pin
    // R14: either request asserts alignment
    always_comb begin
        alignActive = enabled & (~softAlignReq_n | ~pinLevel_n);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame counter on link clock edges

    logic       linkClkLast;
    logic       sysrefLast;
    logic       linkEdge;
    logic       sysrefEdge;
    logic       uiPhase;
    logic       uiTick;
    logic [7:0] uiCount;
    logic       frameStrobe;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkClkLast <= 1'b0;
            sysrefLast  <= 1'b0;
        end else begin
            linkClkLast <= linkClkSync;
            sysrefLast  <= sysrefSync;
        end
    end

    always_comb begin
        linkEdge   = linkClkSync & ~linkClkLast;
        sysrefEdge = sysrefSync & ~sysrefLast;
        // R11: UI is one or two link clocks
        uiTick     = linkEdge & (~demuxBy2 | uiPhase);
    end

    // R3: counter held while disabled, SYSREF ignored
    // R10: frame wraps after frame length UIs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uiPhase <= 1'b0;
            uiCount <= 8'h00;
        end else if (!enabled) begin
            uiPhase <= 1'b0;
            uiCount <= 8'h00;
        end else if (sysrefEdge) begin
            uiPhase <= 1'b0;
            uiCount <= 8'h00;
        end else if (linkEdge) begin
            uiPhase <= demuxBy2 ? ~uiPhase : 1'b0;
            if (uiTick) begin
                uiCount <= (uiCount == frameLenReg - 8'h01) ? 8'h00 : uiCount + 8'h01;
            end
        end
    end

    // Strobe high for the first half of each frame
    always_comb begin
        frameStrobe = enabled & (uiCount < {1'b0, frameLenReg[7:1]});
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample formatting

    logic [11:0] widthMask;
    logic [47:0] formatted;
    logic [47:0] routed;

    // R6: keep the most significant bits only
    always_comb begin
        case (widthSel)
            lvdsc_pkg::LVDSC_W12: widthMask = 12'hFFF;
            lvdsc_pkg::LVDSC_W11: widthMask = 12'hFFE;
            lvdsc_pkg::LVDSC_W10: widthMask = 12'hFFC;
            lvdsc_pkg::LVDSC_W8:  widthMask = 12'hFF0;
            default:              widthMask = 12'hFFF;
        endcase
    end

    // R7: single-channel mode puts inputs B,D on buses A,B and inputs A,C on buses C,D
    always_comb begin
        if (interleave) begin
            routed = {sampleIn[35:24], sampleIn[11:0], sampleIn[47:36], sampleIn[23:12]};
        end else begin
            routed = sampleIn;
        end
    end

    always_comb begin
        formatted = '0;
        for (int b = 0; b < lvdsc_pkg::NUM_BUS; b++) begin
            if (activePatternUser) begin
                formatted[b*12 +: 12] = userPattern;
                // R1: pattern bit 8 inverted on bus A only
                if (b == 0 && invertBusA) begin
                    formatted[lvdsc_pkg::BIT_INVERTED] = ~userPattern[lvdsc_pkg::BIT_INVERTED];
                end
            end else begin
                formatted[b*12 +: 12] = routed[b*12 +: 12];
                // R17: offset binary flips the sign bit
                if (!twosComplement) begin
                    formatted[b*12 + 11] = ~routed[b*12 + 11];
                end
            end
            formatted[b*12 +: 12] = formatted[b*12 +: 12] & widthMask;
            // R18: frame strobe replaces the LSB while aligning
            if (alignActive) begin
                formatted[b*12] = frameStrobe;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scrambling

    lvdsc_lane_if rawLanes ();
    lvdsc_lane_if outLanes ();

    always_comb begin
        rawLanes.data   = formatted;
        rawLanes.strobe = {4{frameStrobe}};
    end

    // R15: lanes and strobes both scrambled
    lvdsc_scrambler u_scrambler (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clear      (~enabled),
        .scrambleOn (scrambleOn),
        .laneIn     (rawLanes),
        .laneOut    (outLanes)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output stage

    logic [3:0]  busesUsed;
    logic [47:0] stageData;
    logic [3:0]  stageStrobe;

    // R9: demux-by-1 drives buses A and C only
    always_comb begin
        busesUsed = demuxBy2 ? 4'hF : 4'h5;
    end

    // Buses B and D trail by one cycle when staggered, spreading switching
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stageData   <= '0;
            stageStrobe <= 4'h0;
        end else begin
            stageData   <= outLanes.data;
            stageStrobe <= outLanes.strobe;
        end
    end

    // R2: disabled interface drives nothing and is powered down
    // R8: staggered or aligned bus timing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busData        <= '0;
            busStrobe      <= 4'h0;
            busEnable      <= 4'h0;
            outputsPowered <= 1'b0;
        end else if (!enabled) begin
            busData        <= '0;
            busStrobe      <= 4'h0;
            busEnable      <= 4'h0;
            outputsPowered <= 1'b0;
        end else begin
            for (int b = 0; b < lvdsc_pkg::NUM_BUS; b++) begin
                if (!busesUsed[b]) begin
                    busData[b*12 +: 12] <= 12'h000;
                    busStrobe[b]        <= 1'b0;
                end else if (!busesAligned && b[0]) begin
                    busData[b*12 +: 12] <= stageData[b*12 +: 12];
                    busStrobe[b]        <= stageStrobe[b];
                end else begin
                    busData[b*12 +: 12] <= outLanes.data[b*12 +: 12];
                    busStrobe[b]        <= outLanes.strobe[b];
                end
            end
            busEnable      <= busesUsed;
            outputsPowered <= 1'b1;
        end
    end

    always_comb begin
        singleChannelMode = interleave;
    end

endmodule

// ===== tb/lvdsc_cfg_sva.sv
/*
 * Port-level checks of the config bank.
 * Assumes it is bound to lvdsc_output_config.
 */
`timescale 1ns/1ps
module lvdsc_cfg_sva (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic [47:0] busData,
    input wire logic [3:0]  busStrobe,
    input wire logic [3:0]  busEnable,
    input wire logic        outputsPowered,
    input wire logic        singleChannelMode,
    input wire logic        alignActive
);
    logic [7:0] enS;
    logic [7:0] modeS;
    logic [7:0] ctrlS;
    logic [7:0] softS;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Shadows of written registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enS   <= 8'h01;
            modeS <= 8'h01;
            ctrlS <= 8'h02;
            softS <= 8'h01;
        end else if (regWrite) begin
            case (regAddr)
                12'h200: enS   <= regWrData;
                12'h201: modeS <= regWrData;
                12'h203: softS <= regWrData;
                12'h204: ctrlS <= regWrData;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_rsvd; regRead && regAddr == 12'h200 |=> regRdData[7:1] == 7'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_rd_back;
        regWrite && regAddr == 12'h202 ##2 regRead && regAddr == 12'h202 |=> regRdData == $past(regWrData, 3);
    endproperty
    a_rd_back: assert property (p_rd_back) else $error("frame readback");
    property p_off; !outputsPowered |-> busEnable == 4'h0 && busStrobe == 4'h0 && busData == 48'h0; endproperty
    a_off: assert property (p_off) else $error("active when off");
    property p_en_lag; regWrite && regAddr == 12'h200 && !regWrData[0] |-> ##[1:2] !outputsPowered; endproperty
    a_en_lag: assert property (p_en_lag) else $error("disable late");
    property p_bus_en; outputsPowered |-> busEnable == (modeS[0] ? 4'hF : 4'h5); endproperty
    a_bus_en: assert property (p_bus_en) else $error("bus enable");
    property p_demux1;
        outputsPowered && !modeS[0] && !ctrlS[4] |-> busData[23:12] == 12'h000 && busData[47:36] == 12'h000;
    endproperty
    a_demux1: assert property (p_demux1) else $error("unused bus");
    property p_width8;
        outputsPowered && modeS[5:4] == 2'b11 && !ctrlS[4] |->
            busData[3:1] == 3'h0 && busData[15:13] == 3'h0 && busData[27:25] == 3'h0 && busData[39:37] == 3'h0;
    endproperty
    a_width8: assert property (p_width8) else $error("width 8");
    property p_single; singleChannelMode == modeS[2]; endproperty
    a_single: assert property (p_single) else $error("channel mode");
    property p_soft; enS[0] && !softS[0] |-> alignActive; endproperty
    a_soft: assert property (p_soft) else $error("soft request");
    property p_src2; ctrlS[3:2] == 2'b10 && softS[0] |-> !alignActive; endproperty
    a_src2: assert property (p_src2) else $error("no source");
endmodule

// ===== tb/lvdsc_rx_model.sv
/*
 * Receiver model: link clock, SYSREF, bus A strobe high time.
 * Assumes run rises only while enabled.
 */
`timescale 1ns/1ps
module lvdsc_rx_model (
    input  wire logic core_clk,
    input  wire logic run,
    input  wire logic busStrobeA,
    output logic      linkClk,
    output logic      sysref,
    output int        highLen
);
    int cnt;

    // Link clock stands still outside a measurement window
    initial begin
        linkClk = 1'b0;
        sysref  = 1'b0;
        cnt     = 0;
        highLen = 0;
        #3;
        forever begin
            #40;
            linkClk = run ? ~linkClk : 1'b0;
        end
    end

    // One SYSREF pulse restarts the frame at each window
    always @(posedge run) begin
        sysref = 1'b1;
        #100;
        sysref = 1'b0;
    end

    always @(posedge core_clk) begin
        if (busStrobeA) begin
            cnt <= cnt + 1;
        end else begin
            if (cnt != 0) highLen <= cnt;
            cnt <= 0;
        end
    end
endmodule

// ===== tb/test_lvds_output_config_regs.sv
/*
 * Self-checking bench for the config bank.
 * Assumes it drives every input.
 */
`timescale 1ns/1ps
module test_lvds_output_config_regs;
    logic        core_clk, rst_n, regWrite, regRead, pinN, patUser, run;
    logic [11:0] regAddr, userPattern;
    logic [7:0]  regWrData, regRdData;
    logic [47:0] sampleIn, busData;
    logic [3:0]  busStrobe, busEnable;
    logic        outputsPowered, singleChannelMode, alignActive, linkClk, sysref;
    int          highLen, n_errors, check_count;

    lvdsc_output_config u_dut (.*, .linkClkIn(linkClk), .sysrefIn(sysref), .alignPinSingleEnded_n(pinN),
        .timestampDiffInput_n(1'b1), .timestampReceiverOn(1'b1), .activePatternUser(patUser));
    lvdsc_rx_model u_rx (.*, .busStrobeA(busStrobe[0]));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge core_clk);
        regWrite  <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(posedge core_clk);
        chk(regRdData, exp, "register read");
    endtask
    task automatic cfg(input logic [7:0] m, input logic [7:0] c, input logic [7:0] f);
        wr(12'h200, 8'h00);
        wr(12'h201, m);
        wr(12'h204, c);
        wr(12'h202, f);
        wr(12'h200, 8'h01);
        repeat (5) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(12'h200, 8'h01);
        rdc(12'h201, 8'h01);
        rdc(12'h202, 8'h80);
        rdc(12'h203, 8'h01);
        rdc(12'h204, 8'h02);
        rdc(12'h190, 8'h00);
        rdc(12'h2FF, 8'h00);
        wr(12'h200, 8'h00);
        wr(12'h202, 8'h40);
        rdc(12'h202, 8'h40);
        $display("test reset done");
    endtask
    task automatic t_format;
        logic [11:0] m;
        sampleIn <= {12'h123, 12'h456, 12'h789, 12'hA5C};
        for (int f = 0; f < 2; f++) begin
            for (int w = 0; w < 4; w++) begin
                cfg(8'h03 | (w[7:0] << 4), 8'h08 | (f[7:0] << 1), 8'h80);
                m = 12'hFFF << ((w == 3) ? 4 : w);
                chk(busData[11:0], (f ? 12'hA5C : 12'h25C) & m, "format");
            end
        end
        chk(busEnable, 4'hF, "four buses");
        cfg(8'h06, 8'h0A, 8'h80);
        chk(busEnable, 4'h5, "two buses");
        chk(singleChannelMode, 1'b1, "single");
        chk(busData[11:0], 12'h789, "routing");
        wr(12'h200, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({outputsPowered, busEnable}, 5'h00, "disabled");
        $display("test format done");
    endtask
    task automatic t_pattern;
        patUser     <= 1'b1;
        userPattern <= 12'h0F0;
        wr(12'h200, 8'h00);
        wr(12'h190, 8'h01);
        cfg(8'h03, 8'h0A, 8'h80);
        chk(busData[11:0], 12'h1F0, "bus A inverted");
        chk(busData[35:24], 12'h0F0, "bus C plain");
        wr(12'h200, 8'h00);
        wr(12'h190, 8'h00);
        $display("test pattern done");
    endtask
    task automatic t_align;
        cfg(8'h03, 8'h0A, 8'h80);
        chk(alignActive, 1'b0, "idle no source");
        wr(12'h203, 8'h00);
        @(posedge core_clk);
        chk(alignActive, 1'b1, "soft request");
        pinN <= 1'b0;
        wr(12'h203, 8'h01);
        repeat (4) @(posedge core_clk);
        chk(alignActive, 1'b0, "stuck pin ignored");
        cfg(8'h03, 8'h02, 8'h80);
        chk(alignActive, 1'b1, "pin source low");
        pinN <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(alignActive, 1'b0, "pin source high");
        $display("test align done");
    endtask
    task automatic t_scramble;
        logic [11:0] a;
        patUser <= 1'b1;
        cfg(8'h03, 8'h1A, 8'h80);
        a = busData[11:0];
        @(posedge core_clk);
        chk(a === busData[11:0], 1'b0, "lane moves");
        chk(busData[11:0] === 12'h0F0, 1'b0, "not plain");
        patUser <= 1'b0;
        $display("test scramble done");
    endtask
    task automatic t_frame;
        for (int d = 0; d < 2; d++) begin
            cfg(8'h02 | d[7:0], 8'h0A, 8'h08);
            run <= 1'b1;
            repeat (450) @(posedge core_clk);
            chk(48'(highLen), d ? 48'd64 : 48'd32, "strobe time");
            run <= 1'b0;
            repeat (20) @(posedge core_clk);
        end
        $display("test frame done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {rst_n, regWrite, regRead, patUser, run} = 5'h00;
        pinN        = 1'b1;
        regAddr     = 12'h000;
        regWrData   = 8'h00;
        userPattern = 12'h000;
        sampleIn    = 48'h0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_format;
        t_pattern;
        t_align;
        t_scramble;
        t_frame;
        tally_and_finish;
    end

    initial begin
        #100us;
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule

bind lvdsc_output_config lvdsc_cfg_sva u_sva (.*);
